/* eccp_steer.sv */
// enhanced capture/compare/pwm unit with output configuration and pin steering
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "eccp_steer_cfg.svh"
module eccp_steer #(
  parameter bit HAS_OUT_CFG = 1'b1,  // 0 on reduced instances
  parameter bit ADC_TRIGGER = 1'b0   // 1 on the unit that starts conversions
) (
  input  wire logic                       ref_clk,      // 25 MHz clock
  input  wire logic                       reset,        // async, active high
  input  wire eccp_steer_pkg::avmm_req_t  avm_req,      // avalon request
  output logic [31:0]                     avm_readdata, // registered read data
  output logic                            avm_waitrequest, // stall until answer
  input  wire logic                       cap_pin,      // pin a input level
  input  wire logic                       fault_in,     // shutdown source, high = fault
  input  wire logic                       adc_enable,   // converter is on
  output eccp_steer_pkg::pin_bundle_t     pins,         // pin a..d level and enable
  output logic                            adc_start,    // one-cycle conversion start
  output logic                            period_pulse  // one-cycle period start
);
  import eccp_steer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  mode_ctrl_r;
  logic [7:0]  duty_high_r;
  logic [4:0]  steer_wr_r;      // software copy of steering register
  logic [3:0]  steer_act_r;     // steering actually in use
  logic        steer_pend_r;
  logic [7:0]  shutdown_r;
  logic [7:0]  timebase_r;
  logic [7:0]  restart_db_r;
  logic [7:0]  period_r;
  logic [15:0] cmp_value_r;
  logic [1:0]  status_r;
  logic [15:0] capture_r;
  logic [15:0] timer16_r;
  logic        ack_r;

  logic        wr_en;
  logic        rd_en;
  logic [3:0]  mode;
  logic [1:0]  out_cfg;
  logic        pwm_mode;
  logic        period_start;
  logic        match_ev;
  logic        match_flag_ev;

  assign mode     = mode_ctrl_r[3:0];
  assign out_cfg  = HAS_OUT_CFG ? mode_ctrl_r[`CFG_MSB:`CFG_LSB] : 2'b00;
  assign pwm_mode = (mode[3:2] == 2'b11);

  function automatic logic sel(input logic [5:0] a, input logic [5:0] ofs);
    sel = (a == ofs);
  endfunction : sel

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: every access answers on the second edge
  assign avm_waitrequest = (avm_req.read | avm_req.write) & ~ack_r;
  assign wr_en = avm_req.write & ~ack_r;
  assign rd_en = avm_req.read & ~ack_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avm_req.read | avm_req.write) & ~ack_r;
    end
  end

  // read mux; unmapped offsets read as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      avm_readdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (avm_req.address)
        `OFS_MODE_CTRL:  avm_readdata <= {24'h000000, out_cfg, mode_ctrl_r[5:0]};
        `OFS_DUTY_HIGH:  avm_readdata <= {24'h000000, duty_high_r};
        `OFS_STEER_CTRL: avm_readdata <= {27'h0, steer_wr_r};
        `OFS_SHUTDOWN:   avm_readdata <= {24'h000000, shutdown_r};
        `OFS_TIMEBASE:   avm_readdata <= {24'h000000, timebase_r};
        `OFS_RESTART_DB: avm_readdata <= {24'h000000, restart_db_r};
        `OFS_PERIOD:     avm_readdata <= {24'h000000, period_r};
        `OFS_CMP_VALUE:  avm_readdata <= {16'h0000, cmp_value_r};
        `OFS_STATUS:     avm_readdata <= {30'h0, status_r};
        `OFS_CAPTURE:    avm_readdata <= {16'h0000, capture_r};
        `OFS_TIMER16:    avm_readdata <= {16'h0000, timer16_r};
        default:         avm_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain control registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_ctrl_r  <= `RST_MODE_CTRL;
      duty_high_r  <= 8'h00;
      timebase_r   <= `RST_TIMEBASE;
      restart_db_r <= `RST_RESTART_DB;
      period_r     <= `RST_PERIOD;
      cmp_value_r  <= 16'h0000;
    end else if (wr_en) begin
      if (sel(avm_req.address, `OFS_MODE_CTRL)) mode_ctrl_r <= avm_req.writedata[7:0];
      if (sel(avm_req.address, `OFS_DUTY_HIGH)) duty_high_r <= avm_req.writedata[7:0];
      if (sel(avm_req.address, `OFS_TIMEBASE)) timebase_r <= avm_req.writedata[7:0];
      if (sel(avm_req.address, `OFS_RESTART_DB)) restart_db_r <= avm_req.writedata[7:0];
      if (sel(avm_req.address, `OFS_PERIOD)) period_r <= avm_req.writedata[7:0];
      if (sel(avm_req.address, `OFS_CMP_VALUE)) cmp_value_r <= avm_req.writedata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // steering: immediate or deferred to the next period start
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      steer_wr_r   <= `RST_STEER_CTRL;   // only pin a enabled
      steer_act_r  <= 4'h1;
      steer_pend_r <= 1'b0;
    end else if (wr_en && sel(avm_req.address, `OFS_STEER_CTRL)) begin
      steer_wr_r <= avm_req.writedata[4:0];
      if (avm_req.writedata[`STEER_SYNC_BIT]) begin
        steer_pend_r <= 1'b1;
      end else begin
        steer_act_r  <= avm_req.writedata[3:0];
        steer_pend_r <= 1'b0;
      end
    end else if (steer_pend_r && period_start) begin
      steer_act_r  <= steer_wr_r[3:0];
      steer_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; only the second stage is read by logic
  logic [1:0] cap_sync_r;
  logic [1:0] flt_sync_r;
  logic       cap_prev_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_sync_r <= 2'b00;
      flt_sync_r <= 2'b00;
      cap_prev_r <= 1'b0;
    end else begin
      cap_sync_r <= {cap_sync_r[0], cap_pin};
      flt_sync_r <= {flt_sync_r[0], fault_in};
      cap_prev_r <= cap_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm time base: 10-bit count, top 8 bits compared with the period
  logic [9:0] pwm_cnt_r;
  logic [9:0] duty_lat_r;
  logic       pwm_raw;

  assign period_start = pwm_mode && (pwm_cnt_r == {period_r, 2'b11});
  assign period_pulse = period_start;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pwm_cnt_r  <= 10'h000;
      duty_lat_r <= 10'h000;
    end else if (!pwm_mode) begin
      pwm_cnt_r  <= 10'h000;
    end else if (period_start) begin
      pwm_cnt_r  <= 10'h000;
      duty_lat_r <= {duty_high_r, mode_ctrl_r[`DLOW_MSB:`DLOW_LSB]};
    end else begin
      pwm_cnt_r  <= pwm_cnt_r + 10'h001;
    end
  end

  assign pwm_raw = pwm_mode && (pwm_cnt_r < duty_lat_r);

  ////////////////////////////////////////////////////////////////////////////
  // 16-bit timer, compare and capture
  logic [4:0] cap_pre_r;
  logic       cmp_out_r;
  logic [3:0] mode_prev_r;
  logic       rise;
  logic       fall;
  logic       cap_ev;

  assign rise     = cap_sync_r[1] & ~cap_prev_r;
  assign fall     = ~cap_sync_r[1] & cap_prev_r;
  assign match_ev = (mode == MODE_CMP_TGL || mode[3:2] == 2'b10) &&
                    (timer16_r == cmp_value_r);
  assign match_flag_ev = match_ev && (mode[3:2] == 2'b10);

  always_comb begin
    case (mode)
      MODE_CAP_FALL: cap_ev = fall;
      MODE_CAP_RISE: cap_ev = rise;
      MODE_CAP_4:    cap_ev = rise && ((cap_pre_r & `CAP_DIV4) == `CAP_DIV4);
      MODE_CAP_16:   cap_ev = rise && ((cap_pre_r & `CAP_DIV16) == `CAP_DIV16);
      default:       cap_ev = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timer16_r <= 16'h0000;
    end else if (match_ev && mode == MODE_CMP_SPEC) begin
      timer16_r <= 16'h0000;
    end else begin
      timer16_r <= timer16_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_pre_r <= 5'h00;
      capture_r <= 16'h0000;
    end else if (mode[3:2] != 2'b01) begin
      cap_pre_r <= 5'h00;
    end else begin
      if (rise) cap_pre_r <= cap_pre_r + 5'h01;
      if (cap_ev) capture_r <= timer16_r;
    end
  end

  // compare pin level; re-initialised whenever the mode changes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_prev_r <= 4'h0;
      cmp_out_r   <= 1'b0;
    end else begin
      mode_prev_r <= mode;
      if (mode != mode_prev_r) begin
        cmp_out_r <= (mode == MODE_CMP_CLR);
      end else if (match_ev) begin
        case (mode)
          MODE_CMP_TGL: cmp_out_r <= ~cmp_out_r;
          MODE_CMP_SET: cmp_out_r <= 1'b1;
          MODE_CMP_CLR: cmp_out_r <= 1'b0;
          default:      cmp_out_r <= cmp_out_r;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= ADC_TRIGGER && adc_enable && match_ev &&
                   (mode == MODE_CMP_SPEC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: write one to clear, a new event wins over the clear
  logic [1:0] st_clr;
  assign st_clr = (wr_en && sel(avm_req.address, `OFS_STATUS)) ?
                  avm_req.writedata[1:0] : 2'b00;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r <= 2'b00;
    end else if (mode == MODE_OFF) begin
      status_r <= 2'b00;
    end else begin
      status_r[`ST_PERIOD_BIT] <= period_start |
        (status_r[`ST_PERIOD_BIT] & ~st_clr[`ST_PERIOD_BIT]);
      status_r[`ST_MATCH_BIT] <= match_flag_ev | cap_ev |
        (status_r[`ST_MATCH_BIT] & ~st_clr[`ST_MATCH_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-shutdown status; hardware set wins over a software clear
  logic fault_act;
  assign fault_act = (shutdown_r[`SRC_MSB:`SRC_LSB] != 3'b000) && flt_sync_r[1];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shutdown_r <= `RST_SHUTDOWN;
    end else begin
      if (wr_en && sel(avm_req.address, `OFS_SHUTDOWN)) begin
        shutdown_r <= avm_req.writedata[7:0];
      end
      if (fault_act) begin
        shutdown_r[`ASE_BIT] <= 1'b1;
      end else if (restart_db_r[`RSEN_BIT] && period_start) begin
        shutdown_r[`ASE_BIT] <= 1'b0;     // auto-restart on a period boundary
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dead-band for half-bridge: delay each inactive-to-active edge
  logic [6:0] db_cnt_r;
  logic       pwm_prev_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      db_cnt_r   <= 7'h00;
      pwm_prev_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_raw;
      if (pwm_raw != pwm_prev_r) begin
        db_cnt_r <= restart_db_r[6:0];
      end else if (db_cnt_r != 7'h00) begin
        db_cnt_r <= db_cnt_r - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin steering and polarity
  logic [3:0]  act_lvl;    // active-high intent per pin
  logic [3:0]  drive;      // pins the unit owns
  logic [3:0]  active_low;
  logic [3:0]  lvl;
  logic [3:0]  oe;
  logic        db_ok;
  logic [1:0]  pss;
  integer      i;

  assign db_ok = (db_cnt_r == 7'h00) && (pwm_raw == pwm_prev_r);
  // pair a/c uses mode bit 1, pair b/d mode bit 0
  assign active_low = {mode[0], mode[1], mode[0], mode[1]};

  always_comb begin
    act_lvl = 4'h0;
    drive   = 4'h0;
    if (!pwm_mode) begin
      act_lvl = {3'b000, cmp_out_r};
      drive   = {3'b000, (mode == MODE_CMP_TGL || mode == MODE_CMP_SET ||
                          mode == MODE_CMP_CLR)};
    end else begin
      case (out_cfg)
        CFG_SINGLE: begin
          act_lvl = {4{pwm_raw}};
          drive   = steer_act_r;
        end
        CFG_FB_FWD: begin
          act_lvl = {pwm_raw, 2'b00, 1'b1};
          drive   = 4'hf;
        end
        CFG_HALF: begin
          act_lvl = {2'b00, ~pwm_raw & db_ok, pwm_raw & db_ok};
          drive   = 4'h3;
        end
        default: begin
          act_lvl = {1'b0, 1'b1, pwm_raw, 1'b0};
          drive   = 4'hf;
        end
      endcase
    end
    lvl = 4'h0;
    oe  = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      lvl[i] = pwm_mode ? (act_lvl[i] ^ active_low[i]) : act_lvl[i];
      oe[i]  = drive[i];
      if (pwm_mode && shutdown_r[`ASE_BIT] && drive[i]) begin
        pss    = (i == 0 || i == 2) ? shutdown_r[3:2] : shutdown_r[1:0];
        lvl[i] = pss[0];
        oe[i]  = ~pss[1];
      end else begin
        pss = 2'b00;
      end
    end
  end

  // pin outputs come from flip-flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pins <= '0;
    end else begin
      pins.level <= lvl;
      pins.oe    <= oe;
    end
  end
endmodule : eccp_steer

/* eccp_steer_cfg.svh */
// register offsets, field positions and reset values for the pwm steering unit
// Functional notes
// - sync clear: steering applies right after write
// - sync set: steering applies at next period
// - steering only in single-output pwm mode
// - low mode bits pick pair polarity
// - period flag sets as each period begins
// - config 00 modulates every steered pin
// - config 01 forward: d modulated, a active
// - config 10 half-bridge a/b with dead-band
// - config 11 reverse: b modulated, c active
// - non-pwm modes: pin a capture/compare only
// - duty low bits extend duty-high to ten
// - mode 0000 resets unit; 0001/0011 reserved
// - capture falling, rising, 4th, 16th rising
// - mode 0010 toggles pin on match
// - 1000/1001 init pin, drive on match, flag
// - mode 1010 only raises match flag
// - 1011 special event resets timer, sets flag
// - reduced instances lack output configuration field
// - steer bit routes pwm; reset enables a
// - shutdown only touches pins the unit drives
`ifndef ECCP_STEER_CFG_SVH
`define ECCP_STEER_CFG_SVH

`define OFS_MODE_CTRL    6'h00
`define OFS_DUTY_HIGH    6'h04
`define OFS_STEER_CTRL   6'h08
`define OFS_SHUTDOWN     6'h0c
`define OFS_TIMEBASE     6'h10
`define OFS_RESTART_DB   6'h14
`define OFS_PERIOD       6'h18
`define OFS_CMP_VALUE    6'h1c
`define OFS_STATUS       6'h20
`define OFS_CAPTURE      6'h24
`define OFS_TIMER16      6'h28

`define RST_MODE_CTRL    8'h00
`define RST_STEER_CTRL   5'h01
`define RST_SHUTDOWN     8'h00
`define RST_TIMEBASE     8'h00
`define RST_RESTART_DB   8'h00
`define RST_PERIOD       8'hff

`define CFG_MSB          7
`define CFG_LSB          6
`define DLOW_MSB         5
`define DLOW_LSB         4
`define STEER_SYNC_BIT   4
`define ASE_BIT          7
`define SRC_MSB          6
`define SRC_LSB          4
`define RSEN_BIT         7
`define ST_PERIOD_BIT    0
`define ST_MATCH_BIT     1

`define CAP_DIV4         5'h03
`define CAP_DIV16        5'h0f
`endif

/* eccp_steer_pkg.sv */
// types shared by the pwm steering unit and its bench
package eccp_steer_pkg;
  typedef enum logic [3:0] {
    MODE_OFF      = 4'b0000,
    MODE_RSV1     = 4'b0001,
    MODE_CMP_TGL  = 4'b0010,
    MODE_RSV3     = 4'b0011,
    MODE_CAP_FALL = 4'b0100,
    MODE_CAP_RISE = 4'b0101,
    MODE_CAP_4    = 4'b0110,
    MODE_CAP_16   = 4'b0111,
    MODE_CMP_SET  = 4'b1000,
    MODE_CMP_CLR  = 4'b1001,
    MODE_CMP_SW   = 4'b1010,
    MODE_CMP_SPEC = 4'b1011
  } ccp_mode_t;

  typedef enum logic [1:0] {
    CFG_SINGLE  = 2'b00,
    CFG_FB_FWD  = 2'b01,
    CFG_HALF    = 2'b10,
    CFG_FB_REV  = 2'b11
  } out_cfg_t;

  // the four unit pins: level driven and drive enable
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pin_bundle_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;
endpackage : eccp_steer_pkg

/* eccp_steer_monitor.sv */
// concurrent checks on the ports of the pwm steering unit
`timescale 1ns/1ps
`include "eccp_steer_cfg.svh"
module eccp_steer_monitor
  import eccp_steer_pkg::*;
#(
  parameter bit HAS_OUT_CFG = 1'b1,  // output config field present
  parameter bit ADC_TRIGGER = 1'b0   // unit may start conversions
) (
  input wire logic                        ref_clk,         // clock
  input wire logic                        reset,           // async reset
  input wire eccp_steer_pkg::avmm_req_t   avm_req,         // bus request
  input wire logic [31:0]                 avm_readdata,    // read data
  input wire logic                        avm_waitrequest, // stall
  input wire logic                        cap_pin,         // capture input
  input wire logic                        fault_in,        // fault source
  input wire logic                        adc_enable,      // converter on
  input wire eccp_steer_pkg::pin_bundle_t pins,            // pin outputs
  input wire logic                        adc_start,       // conversion start
  input wire logic                        period_pulse     // period start
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic       req, acc, wr_acc, single, calm, sd_r;
  logic [7:0] mode_r, steer_r;
  logic [5:0] quiet_r, squiet_r;
  logic [4:0] oe_x;
  assign req    = avm_req.read | avm_req.write;
  assign acc    = req & ~avm_waitrequest;
  assign wr_acc = acc & avm_req.write;
  assign single = (mode_r[3:2] == 2'b11) && (mode_r[7:6] == 2'b00);
  // long settle window: shadows lag the unit and steering may wait a period
  assign calm   = (quiet_r > 6'h28) && !sd_r;
  assign oe_x   = exp_oe(mode_r, steer_r[3:0]);
  ////////////////////////////////////////////////////////////////////////////
  // expected pin enables; special event mode left open (bit 4 clear)
  function automatic logic [4:0] exp_oe(input logic [7:0] m, input logic [3:0] s);
    if (m[3:2] == 2'b11) begin
      case (m[7:6])
        2'b00:   return {1'b1, s};
        2'b10:   return 5'h13;
        default: return 5'h1f;
      endcase
    end
    case (m[3:0])
      4'h2, 4'h8, 4'h9: return 5'h11;
      4'hb:             return 5'h00;
      default:          return 5'h10;
    endcase
  endfunction : exp_oe
  // shadow registers taken when the master sees its write accepted
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r  <= 8'h00;
      steer_r <= 8'h01;
      sd_r    <= 1'b0;
    end else if (wr_acc) begin
      if (avm_req.address == `OFS_MODE_CTRL) mode_r <= avm_req.writedata[7:0];
      if (avm_req.address == `OFS_STEER_CTRL) steer_r <= {3'h0, avm_req.writedata[4:0]};
      if (avm_req.address == `OFS_SHUTDOWN) sd_r <= 1'b1;
    end
  end
  // cycles since control writes, saturating
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      quiet_r  <= 6'h00;
      squiet_r <= 6'h00;
    end else begin
      if (wr_acc && avm_req.address != `OFS_STEER_CTRL && avm_req.address != `OFS_STATUS)
        quiet_r <= 6'h00;
      else if (quiet_r != 6'h3f) quiet_r <= quiet_r + 6'h01;
      if (wr_acc && avm_req.address == `OFS_STEER_CTRL) squiet_r <= 6'h00;
      else if (squiet_r != 6'h3f) squiet_r <= squiet_r + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_wait_first: assert property ($rose(req) |-> avm_waitrequest)
    else $error("first request cycle not stalled");
  a_wait_once: assert property (req && avm_waitrequest |=> !avm_waitrequest)
    else $error("more than one wait cycle");
  a_idle_nowait: assert property (!req |-> !avm_waitrequest)
    else $error("stall without request");
  a_unmapped_zero: assert property (acc && avm_req.read && avm_req.address > 6'h28
    |-> avm_readdata == 32'h0) else $error("unmapped read not zero");
  a_steer_readback: assert property (acc && avm_req.read && avm_req.address ==
    `OFS_STEER_CTRL |-> avm_readdata == {24'h0, steer_r})
    else $error("steering readback wrong");
  a_steer_now: assert property (wr_acc && avm_req.address == `OFS_STEER_CTRL &&
    !avm_req.writedata[4] && single && calm |=> pins.oe == $past(avm_req.writedata[3:0]))
    else $error("unsynced steering late");
  a_steer_sync: assert property ($changed(pins.oe) && steer_r[4] && single && calm
    |-> $past(period_pulse) || $past(period_pulse, 2)) else $error("synced steer mid period");
  a_oe_map: assert property (calm && squiet_r > 6'h28 && oe_x[4]
    |-> pins.oe == oe_x[3:0]) else $error("pin enables wrong for mode");
  a_pair_level: assert property (calm && single && steer_r[3:0] == 4'hf &&
    squiet_r > 6'h28 |-> pins.level[0] == pins.level[2] && pins.level[1] == pins.level[3] &&
    (pins.level[0] ^ pins.level[1]) == (mode_r[1] ^ mode_r[0])) else $error("pair polarity");
  a_pulse_gap: assert property (period_pulse |=> !period_pulse [*3])
    else $error("period pulses too close");
  a_adc_gate: assert property (adc_start |-> ADC_TRIGGER && $past(adc_enable))
    else $error("conversion start not allowed");
  c_sync_write: cover property (wr_acc && avm_req.address == `OFS_STEER_CTRL && avm_req.writedata[4]);
  c_adc: cover property (adc_start);
  c_period: cover property (single && calm && period_pulse);
endmodule : eccp_steer_monitor

/* bridge_driver_model.sv */
// external bridge drivers: pad pull-downs and a gated switch stage
`timescale 1ns/1ps
module bridge_driver_model (
  input wire eccp_steer_pkg::pin_bundle_t pins,   // unit pin outputs
  input wire logic                        drv_en, // firmware enables drivers
  output logic [3:0]                      pad,    // resolved pad level
  output logic [3:0]                      gate    // switch gate drive
);
  // released pads fall to the pull-down so the switches stay off
  assign pad  = pins.level & pins.oe;
  // switches follow the pads only once drivers are enabled
  assign gate = drv_en ? pad : 4'h0;
endmodule : bridge_driver_model

/* tb.sv */
// self-checking bench for the pwm steering unit
`timescale 1ns/1ps
`include "eccp_steer_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import eccp_steer_pkg::*;
  logic        ref_clk, reset, wait_rq, cap_pin, fault_in, adc_enable, adc_start, pulse;
  logic        drv_en, lv;
  avmm_req_t   req;
  pin_bundle_t pins;
  logic [31:0] rdata, q, r;
  logic [3:0]  pad, gate, steer, cm;
  logic [7:0]  mv;
  logic [3:0]  cmp_modes [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
  int          mismatches, n_checks, seed, adc_cnt, m, i, n, ne;
  eccp_steer #(.HAS_OUT_CFG(1'b1), .ADC_TRIGGER(1'b1)) DUT (.ref_clk(ref_clk),
    .reset(reset), .avm_req(req), .avm_readdata(rdata), .avm_waitrequest(wait_rq),
    .cap_pin(cap_pin), .fault_in(fault_in), .adc_enable(adc_enable), .pins(pins),
    .adc_start(adc_start), .period_pulse(pulse));
  bridge_driver_model u_drv (.pins(pins), .drv_en(drv_en), .pad(pad), .gate(gate));
  always #20 ref_clk = ~ref_clk;
  // count conversion starts for the special event check
  always @(posedge ref_clk) if (adc_start === 1'b1) adc_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    req <= '{read: ~wr, write: wr, address: a, writedata: d};
    k = 0;
    do begin @(posedge ref_clk); k++; end while (wait_rq !== 1'b0 && k < 20);
    q = rdata;
    if (k == 20) begin mismatches++; results(); end
    req <= '0;
  endtask : bus
  task automatic pulse_cap();
    cap_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cap_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse_cap
  // high cycles on pin a in one 16-count period
  function automatic logic [4:0] exp_ones(input logic [3:0] d, input logic pol, input logic on);
    return on ? (pol ? 5'h10 - {1'b0, d} : {1'b0, d}) : 5'h00;
  endfunction : exp_ones
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2a2ea8b5; mismatches = 0; n_checks = 0; adc_cnt = 0;
    ref_clk = 1'b0; reset = 1'b1; req = '0; cap_pin = 1'b0; fault_in = 1'b0;
    adc_enable = 1'b1; drv_en = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    bus(1'b0, `OFS_STEER_CTRL, 32'h0); `CHK(q[7:0], 8'h01)
    bus(1'b0, `OFS_PERIOD, 32'h0); `CHK(q[7:0], 8'hff)
    bus(1'b1, 6'h30, 32'hff); bus(1'b0, 6'h30, 32'h0); `CHK(q, 32'h0)
    bus(1'b1, `OFS_PERIOD, 32'h3);
    // every mode code with every config code; pin enables watched by the checker
    for (m = 0; m < 64; m++) begin
      mv = {m[5:4], 2'b00, m[3:0]};
      bus(1'b1, `OFS_MODE_CTRL, {24'h0, mv});
      repeat (44) @(posedge ref_clk);
      bus(1'b0, `OFS_MODE_CTRL, 32'h0); `CHK(q[7:0], mv)
      if (m[3:0] == 0) begin bus(1'b0, `OFS_STATUS, 32'h0); `CHK(q[1:0], 2'b00) end
    end
    // random polarity, duty and steering in single output
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      steer = (i == 0) ? 4'hf : r[3:0]; // all-zero steering leaves pins idle
      bus(1'b1, `OFS_MODE_CTRL, {24'h0, 2'b00, r[5:4], 2'b11, r[7:6]}); // drivers off
      bus(1'b1, `OFS_DUTY_HIGH, {30'h0, r[9:8]});
      bus(1'b1, `OFS_STEER_CTRL, {28'h0, steer});
      bus(1'b1, `OFS_STATUS, 32'h3);
      repeat (40) @(posedge ref_clk);
      bus(1'b0, `OFS_STATUS, 32'h0); `CHK(q[0], 1'b1)
      drv_en <= 1'b1; // only after a full period was flagged
      n = 0;
      repeat (16) begin @(posedge ref_clk); n += (gate[0] === 1'b1); end
      `CHK(n[4:0], exp_ones({r[9:8], r[5:4]}, r[7], steer[0]))
      drv_en <= 1'b0;
    end
    // synced steering waits for the period, unsynced acts at once
    bus(1'b1, `OFS_STEER_CTRL, 32'h1f);
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pulse !== 1'b1 && n < 2000);
    if (n == 2000) begin mismatches++; results(); end
    repeat (3) @(posedge ref_clk);
    `CHK(pins.oe, 4'hf)
    bus(1'b1, `OFS_STEER_CTRL, 32'h02); @(posedge ref_clk); `CHK(pins.oe, 4'h2)
    // compare modes, each entered just after the special event cleared the timer
    for (i = 0; i < 4; i++) begin
      cm = cmp_modes[i];
      adc_enable <= i[0];
      bus(1'b0, `OFS_TIMER16, 32'h0); bus(1'b1, `OFS_CMP_VALUE, q + 32'h20);
      bus(1'b1, `OFS_MODE_CTRL, 32'h0b);
      repeat (60) @(posedge ref_clk);
      bus(1'b1, `OFS_CMP_VALUE, 32'h30);
      bus(1'b0, `OFS_STATUS, 32'h0); `CHK(q[1], 1'b1)
      n = 0;
      do begin bus(1'b0, `OFS_TIMER16, 32'h0); n++; end while (q[15:0] > 16'h10 && n < 40);
      `CHK(q[15:0] <= 16'h30, 1'b1)
      bus(1'b1, `OFS_MODE_CTRL, {28'h0, cm});
      bus(1'b1, `OFS_STATUS, 32'h3);
      lv = pins.level[0];
      if (cm[3:1] == 3'b100) `CHK(lv, cm[0])
      repeat (60) @(posedge ref_clk);
      if (cm != 4'ha) `CHK(pins.level[0], ~lv)
      else `CHK(pins.oe[0], 1'b0)
      bus(1'b0, `OFS_STATUS, 32'h0);
      if (cm != 4'h2) `CHK(q[1], 1'b1)
    end
    `CHK(adc_cnt > 0, 1'b1)
    // capture modes need 1, 1, 4 and 16 edges
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `OFS_MODE_CTRL, 32'h0);
      bus(1'b1, `OFS_MODE_CTRL, 32'h4 + i);
      bus(1'b1, `OFS_STATUS, 32'h3);
      ne = (i < 2) ? 1 : ((i == 2) ? 4 : 16);
      repeat (ne - 1) pulse_cap();
      bus(1'b0, `OFS_STATUS, 32'h0); `CHK(q[1], 1'b0)
      pulse_cap();
      bus(1'b0, `OFS_STATUS, 32'h0); `CHK(q[1], 1'b1)
    end
    // fault drives only the steered pins to their shutdown level
    bus(1'b1, `OFS_MODE_CTRL, 32'h0c);
    bus(1'b1, `OFS_STEER_CTRL, 32'h05);
    bus(1'b1, `OFS_SHUTDOWN, 32'h15);
    fault_in <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK(pins.oe, 4'h5)
    `CHK(pins.level & 4'h5, 4'h5)
    fault_in <= 1'b0;
    results();
  end
endmodule : tb
bind eccp_steer eccp_steer_monitor #(.HAS_OUT_CFG(HAS_OUT_CFG), .ADC_TRIGGER(ADC_TRIGGER))
  u_mon (.ref_clk(ref_clk), .reset(reset), .avm_req(avm_req), .avm_readdata(avm_readdata),
  .avm_waitrequest(avm_waitrequest), .cap_pin(cap_pin), .fault_in(fault_in),
  .adc_enable(adc_enable), .pins(pins), .adc_start(adc_start), .period_pulse(period_pulse));
